// file: design/cpr_core_state.sv
// Core privilege, mode, banked stack and special register state.
// Assumes one clock, a register port that never waits, and a pipeline
// that raises call, exception entry and return events as single pulses.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module cpr_core_state
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  input  wire cpr_pkg::cpr_gpr_req_t gpr_req,
  output logic [31:0]                gpr_rdata,
  input  wire logic                  call_pulse,
  input  wire logic [31:0]           call_ret_addr,
  input  wire logic                  exc_entry,
  input  wire logic [8:0]            exc_num,
  input  wire logic                  exc_return,
  input  wire cpr_pkg::cpr_int_req_t int_req,
  output logic                       int_accept,
  output logic                       fault,
  output cpr_pkg::cpr_mode_t         mode,
  output logic                       proc_stack_sel,
  output logic                       privileged,
  output logic                       irq
);
  import cpr_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [31:0] gpr_r [0:12];
  logic [31:0] link_return_r;
  logic [31:0] program_counter_r;
  logic [31:0] main_stack_ptr_r;
  logic [31:0] process_stack_ptr_r;
  logic [31:0] psr_bits_r;
  logic [8:0]  exc_number_r;
  logic        priority_mask_bit_r;
  logic        fault_mask_bit_r;
  logic [8:0]  base_priority_threshold_r;
  logic [1:0]  ctrl_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_mask_r;
  cpr_mode_t   mode_r;
  cpr_mode_t   mode_nxt;
  logic [1:0]  ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] gpr_rdata_r;
  logic        accept_r;
  logic        fault_r;
  logic        proc_stack_r;
  logic        priv_r;
  logic        irq_r;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] align_word(input logic [31:0] v);
    align_word = {v[31:2], 2'b00};
  endfunction

  function automatic logic [31:0] align_half(input logic [31:0] v);
    align_half = {v[31:1], 1'b0};
  endfunction

  function automatic logic use_proc_stack(input cpr_mode_t m, input logic [1:0] c);
    use_proc_stack = (m == CPR_THREAD_USER) && c[CPR_CTRL_ALTSP];
  endfunction

  logic        sel_proc_stack;
  logic [31:0] psr_value;
  assign sel_proc_stack = use_proc_stack(mode_r, ctrl_r);
  assign psr_value      = (psr_bits_r & CPR_PSR_WMASK) | CPR_PSR_ONE | {23'h0, exc_number_r};

  function automatic logic [31:0] core_reg(input logic [3:0] idx);
    if (idx == CPR_IDX_STACK)
      core_reg = sel_proc_stack ? process_stack_ptr_r : main_stack_ptr_r;
    else if (idx == CPR_IDX_LINK)
      core_reg = link_return_r;
    else if (idx == CPR_IDX_PROG)
      core_reg = program_counter_r;
    else
      core_reg = gpr_r[idx];
  endfunction

  // ==========================================================================
  // Access decode
  // ==========================================================================
  logic       bus_gpr;
  logic [3:0] bus_idx;
  logic       bus_special;
  logic       bus_blocked;
  logic       bus_gw;
  logic       core_gw;
  logic       core_hi_bad;
  logic       compact_clear;
  logic [3:0] ev_set;
  logic       accept_nxt;

  assign bus_gpr     = (reg_addr <= CPR_OFF_GPR_LAST) && (reg_addr[1:0] == 2'b00);
  assign bus_idx     = reg_addr[5:2];
  assign bus_special = (reg_addr == CPR_OFF_PSR) || (reg_addr == CPR_OFF_PRIO_MASK)
                    || (reg_addr == CPR_OFF_FAULT_MASK) || (reg_addr == CPR_OFF_BASE_PRIO)
                    || (reg_addr == CPR_OFF_CONTROL) || (reg_addr == CPR_OFF_MAIN_STACK)
                    || (reg_addr == CPR_OFF_PROC_STACK);
  // User level writes to special registers are refused and fault.
  assign bus_blocked = reg_wr && bus_special && !priv_r;
  assign bus_gw      = reg_wr && bus_gpr;
  // A 16-bit instruction cannot name the high registers.
  assign core_hi_bad = gpr_req.valid && gpr_req.is16
                    && (gpr_req.idx >= CPR_IDX_HIGH_LO) && (gpr_req.idx <= CPR_IDX_HIGH_HI);
  assign core_gw     = gpr_req.valid && gpr_req.wr && !core_hi_bad;
  // Attempting to clear the compact state bit faults.
  assign compact_clear = reg_wr && (reg_addr == CPR_OFF_PSR) && priv_r
                      && !reg_wdata[CPR_PSR_COMPACT];

  always_comb
  begin
    ev_set                = 4'h0;
    ev_set[CPR_EV_FAULT]  = bus_blocked || core_hi_bad || compact_clear;
    ev_set[CPR_EV_ENTRY]  = exc_entry;
    ev_set[CPR_EV_RETURN] = exc_return && !exc_entry;
    ev_set[CPR_EV_REFUSE] = int_req.valid && !accept_nxt;
  end

  // ==========================================================================
  // Exception acceptance
  // ==========================================================================
  always_comb
  begin
    if (int_req.nmi)
      accept_nxt = 1'b1;
    else if (fault_mask_bit_r)
      accept_nxt = 1'b0;
    else if (int_req.hardfault)
      accept_nxt = 1'b1;
    else if (priority_mask_bit_r)
      accept_nxt = 1'b0;
    else if ((base_priority_threshold_r != 9'h000)
             && (int_req.prio >= base_priority_threshold_r))
      accept_nxt = 1'b0;
    else
      accept_nxt = 1'b1;
  end

  // ==========================================================================
  // Mode and control
  // ==========================================================================
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (reg_wr && (reg_addr == CPR_OFF_CONTROL) && priv_r)
      ctrl_nxt = reg_wdata[1:0];
    mode_nxt = mode_r;
    unique case (mode_r)
      CPR_THREAD_PRIV, CPR_THREAD_USER:
      begin
        mode_nxt = ctrl_nxt[CPR_CTRL_USER] ? CPR_THREAD_USER : CPR_THREAD_PRIV;
      end
      CPR_HANDLER:
      begin
        if (exc_return)
          mode_nxt = ctrl_nxt[CPR_CTRL_USER] ? CPR_THREAD_USER : CPR_THREAD_PRIV;
      end
      default:
      begin
        mode_nxt = CPR_THREAD_PRIV;
      end
    endcase
    if (exc_entry)
      mode_nxt = CPR_HANDLER;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_r <= CPR_THREAD_PRIV;
      ctrl_r <= CPR_RST_CONTROL;
      proc_stack_r <= 1'b0;
      priv_r <= 1'b1;
    end
    else
    begin
      mode_r <= mode_nxt;
      ctrl_r <= ctrl_nxt;
      // The process stack is chosen only in user thread operation.
      proc_stack_r <= use_proc_stack(mode_nxt, ctrl_nxt);
      // Handler mode is always privileged.
      priv_r <= (mode_nxt != CPR_THREAD_USER);
    end
  end

  // ==========================================================================
  // Core registers
  // ==========================================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i <= 12; i++)
        gpr_r[i] <= CPR_RST_WORD;
    end
    else
    begin
      for (int i = 0; i <= 12; i++)
      begin
        if (bus_gw && (bus_idx == 4'(i)))
          gpr_r[i] <= reg_wdata;
        if (core_gw && (gpr_req.idx == 4'(i)))
          gpr_r[i] <= gpr_req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_return_r     <= CPR_RST_WORD;
      program_counter_r <= CPR_RST_WORD;
    end
    else
    begin
      if (bus_gw && (bus_idx == CPR_IDX_LINK))
        link_return_r <= reg_wdata;
      if (core_gw && (gpr_req.idx == CPR_IDX_LINK))
        link_return_r <= gpr_req.wdata;
      if (call_pulse)
        link_return_r <= call_ret_addr;
      if (bus_gw && (bus_idx == CPR_IDX_PROG))
        program_counter_r <= align_half(reg_wdata);
      if (core_gw && (gpr_req.idx == CPR_IDX_PROG))
        program_counter_r <= align_half(gpr_req.wdata);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      main_stack_ptr_r    <= CPR_RST_WORD;
      process_stack_ptr_r <= CPR_RST_WORD;
    end
    else
    begin
      if (reg_wr && (reg_addr == CPR_OFF_MAIN_STACK) && priv_r)
        main_stack_ptr_r <= align_word(reg_wdata);
      if (reg_wr && (reg_addr == CPR_OFF_PROC_STACK) && priv_r)
        process_stack_ptr_r <= align_word(reg_wdata);
      if (bus_gw && (bus_idx == CPR_IDX_STACK))
      begin
        if (sel_proc_stack)
          process_stack_ptr_r <= align_word(reg_wdata);
        else
          main_stack_ptr_r <= align_word(reg_wdata);
      end
      if (core_gw && (gpr_req.idx == CPR_IDX_STACK))
      begin
        if (sel_proc_stack)
          process_stack_ptr_r <= align_word(gpr_req.wdata);
        else
          main_stack_ptr_r <= align_word(gpr_req.wdata);
      end
    end
  end

  // ==========================================================================
  // Status and mask registers
  // ==========================================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      psr_bits_r                <= CPR_RST_WORD;
      exc_number_r              <= 9'h000;
      priority_mask_bit_r       <= 1'b0;
      fault_mask_bit_r          <= 1'b0;
      base_priority_threshold_r <= CPR_RST_THRESH;
    end
    else
    begin
      // Flags in 31:27 and execution state in 26:25 and 15:10.
      if (reg_wr && (reg_addr == CPR_OFF_PSR) && priv_r)
        psr_bits_r <= reg_wdata & CPR_PSR_WMASK;
      if (exc_entry)
        exc_number_r <= exc_num;
      else if (exc_return)
        exc_number_r <= 9'h000;
      if (reg_wr && (reg_addr == CPR_OFF_PRIO_MASK) && priv_r)
        priority_mask_bit_r <= reg_wdata[0];
      if (reg_wr && (reg_addr == CPR_OFF_FAULT_MASK) && priv_r)
        fault_mask_bit_r <= reg_wdata[0];
      if (reg_wr && (reg_addr == CPR_OFF_BASE_PRIO) && priv_r)
        base_priority_threshold_r <= reg_wdata[8:0];
    end
  end

  // Event status is write-one-to-clear; a new event wins over its clear.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat_r <= CPR_RST_IRQ;
      irq_mask_r <= CPR_RST_IRQ;
      irq_r      <= 1'b0;
    end
    else
    begin
      if (reg_wr && (reg_addr == CPR_OFF_IRQ_STAT))
        irq_stat_r <= (irq_stat_r & ~reg_wdata[3:0]) | ev_set;
      else
        irq_stat_r <= irq_stat_r | ev_set;
      if (reg_wr && (reg_addr == CPR_OFF_IRQ_MASK))
        irq_mask_r <= reg_wdata[3:0];
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ==========================================================================
  // Read paths and pulses
  // ==========================================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_r     <= CPR_RST_WORD;
      gpr_rdata_r <= CPR_RST_WORD;
      accept_r    <= 1'b0;
      fault_r     <= 1'b0;
    end
    else
    begin
      accept_r    <= int_req.valid && accept_nxt;
      fault_r     <= ev_set[CPR_EV_FAULT];
      gpr_rdata_r <= (gpr_req.valid && !gpr_req.wr) ? core_reg(gpr_req.idx) : CPR_RST_WORD;
      if (!reg_rd)
        rdata_r <= CPR_RST_WORD;
      else if (bus_gpr)
        rdata_r <= core_reg(bus_idx);
      else
      begin
        unique case (reg_addr)
          CPR_OFF_PSR:        rdata_r <= psr_value;
          CPR_OFF_PRIO_MASK:  rdata_r <= {31'h0, priority_mask_bit_r};
          CPR_OFF_FAULT_MASK: rdata_r <= {31'h0, fault_mask_bit_r};
          CPR_OFF_BASE_PRIO:  rdata_r <= {23'h0, base_priority_threshold_r};
          CPR_OFF_CONTROL:    rdata_r <= {30'h0, ctrl_r};
          CPR_OFF_MAIN_STACK: rdata_r <= main_stack_ptr_r;
          CPR_OFF_PROC_STACK: rdata_r <= process_stack_ptr_r;
          CPR_OFF_IRQ_STAT:   rdata_r <= {28'h0, irq_stat_r};
          CPR_OFF_IRQ_MASK:   rdata_r <= {28'h0, irq_mask_r};
          CPR_OFF_MODE:       rdata_r <= {29'h0, priv_r, mode_r};
          default:            rdata_r <= CPR_RST_WORD;
        endcase
      end
    end
  end

  assign reg_rdata   = rdata_r;
  assign gpr_rdata   = gpr_rdata_r;
  assign int_accept  = accept_r;
  assign fault       = fault_r;
  assign mode        = mode_r;
  assign proc_stack_sel = proc_stack_r;
  assign privileged  = priv_r;
  assign irq         = irq_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  handler_priv_a: assert property (mode_r == CPR_HANDLER |-> priv_r)
    else $error("handler mode without privilege");
  user_block_a: assert property (reg_wr && bus_special && !priv_r
    |=> fault_r && $stable(ctrl_r) && $stable(fault_mask_bit_r))
    else $error("user level special write not refused");
  entry_main_a: assert property (exc_entry |=> mode_r == CPR_HANDLER && !proc_stack_r)
    else $error("exception entry did not select handler on main stack");
  high_reg_a: assert property (core_hi_bad |=> fault_r)
    else $error("16-bit access to high register not faulted");
  user_stack_a: assert property (proc_stack_r
    |-> mode_r == CPR_THREAD_USER && ctrl_r[1])
    else $error("process stack outside user thread");
  sp_align_a: assert property (main_stack_ptr_r[1:0] == 2'b00
    && process_stack_ptr_r[1:0] == 2'b00)
    else $error("stack pointer not word aligned");
  call_link_a: assert property (call_pulse |=> link_return_r == $past(call_ret_addr))
    else $error("link register missed return address");
  pc_align_a: assert property (program_counter_r[0] == 1'b0)
    else $error("program counter not halfword aligned");
  exc_num_a: assert property (exc_entry ##1 (!exc_entry && !exc_return) [*2]
    |-> exc_number_r == $past(exc_num, 2))
    else $error("exception number not held");
  compact_bit_a: assert property (reg_rd && reg_addr == CPR_OFF_PSR
    |=> rdata_r[CPR_PSR_COMPACT])
    else $error("compact state bit read as zero");
  nmi_pass_a: assert property (int_req.valid && int_req.nmi |=> accept_r)
    else $error("nonmaskable interrupt refused");
  prio_mask_a: assert property (int_req.valid && !int_req.nmi
    && !int_req.hardfault && priority_mask_bit_r |=> !accept_r)
    else $error("priority mask did not block");
  base_mask_a: assert property (int_req.valid && !int_req.nmi && !int_req.hardfault
    && base_priority_threshold_r != 9'h000 && int_req.prio >= base_priority_threshold_r
    |=> !accept_r)
    else $error("base priority did not block");
  return_mode_a: assert property (exc_return && !exc_entry && mode_r == CPR_HANDLER
    |=> mode_r == (ctrl_r[0] ? CPR_THREAD_USER : CPR_THREAD_PRIV))
    else $error("return did not follow control");

  entry_ret_c: cover property (exc_entry ##[1:20] exc_return);
  user_stack_c: cover property (proc_stack_r ##1 exc_entry ##1 !proc_stack_r);
  refuse_c: cover property (int_req.valid && fault_mask_bit_r ##1 irq_stat_r[CPR_EV_REFUSE]);

endmodule

`default_nettype wire

// file: pkg/cpr_pkg.sv
// Constants and carrier types of the processor core state register file.
// Assumes a single clock domain and a plain byte-addressed register port.
package cpr_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] CPR_OFF_GPR_LAST   = 8'h3C;
  localparam logic [7:0] CPR_OFF_PSR        = 8'h40;
  localparam logic [7:0] CPR_OFF_PRIO_MASK  = 8'h44;
  localparam logic [7:0] CPR_OFF_FAULT_MASK = 8'h48;
  localparam logic [7:0] CPR_OFF_BASE_PRIO  = 8'h4C;
  localparam logic [7:0] CPR_OFF_CONTROL    = 8'h50;
  localparam logic [7:0] CPR_OFF_MAIN_STACK = 8'h54;
  localparam logic [7:0] CPR_OFF_PROC_STACK = 8'h58;
  localparam logic [7:0] CPR_OFF_IRQ_STAT   = 8'h5C;
  localparam logic [7:0] CPR_OFF_IRQ_MASK   = 8'h60;
  localparam logic [7:0] CPR_OFF_MODE       = 8'h64;

  // ==========================================================================
  // Register indices and fields
  // ==========================================================================
  localparam logic [3:0]  CPR_IDX_HIGH_LO  = 4'h8;
  localparam logic [3:0]  CPR_IDX_HIGH_HI  = 4'hC;
  localparam logic [3:0]  CPR_IDX_STACK    = 4'hD;
  localparam logic [3:0]  CPR_IDX_LINK     = 4'hE;
  localparam logic [3:0]  CPR_IDX_PROG     = 4'hF;
  localparam logic [31:0] CPR_PSR_WMASK    = 32'hFE00_FC00;
  localparam int          CPR_PSR_COMPACT  = 24;
  localparam logic [31:0] CPR_PSR_ONE      = 32'h0100_0000;
  localparam int          CPR_CTRL_USER    = 0;
  localparam int          CPR_CTRL_ALTSP   = 1;

  // Interrupt status bits: fault, exception entry, exception return, refused.
  localparam int          CPR_EV_FAULT     = 0;
  localparam int          CPR_EV_ENTRY     = 1;
  localparam int          CPR_EV_RETURN    = 2;
  localparam int          CPR_EV_REFUSE    = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] CPR_RST_WORD     = 32'h0000_0000;
  localparam logic [1:0]  CPR_RST_CONTROL  = 2'h0;
  localparam logic [8:0]  CPR_RST_THRESH   = 9'h000;
  localparam logic [3:0]  CPR_RST_IRQ      = 4'h0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    CPR_THREAD_PRIV = 2'b00,
    CPR_THREAD_USER = 2'b01,
    CPR_HANDLER     = 2'b11
  } cpr_mode_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic        is16;
    logic [3:0]  idx;
    logic [31:0] wdata;
  } cpr_gpr_req_t;

  typedef struct packed {
    logic       valid;
    logic       nmi;
    logic       hardfault;
    logic [8:0] prio;
  } cpr_int_req_t;

endpackage

// file: verification/tb.sv
// Self-checking bench for the core state register file.
// Assumes a 25 MHz clock and drives every port from the bench itself.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import cpr_pkg::*;

  // ==========================================================================
  // Stimulus and instance
  // ==========================================================================
  logic         clk;
  logic         reset_n;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_rdata;
  cpr_gpr_req_t gpr_req;
  logic [31:0]  gpr_rdata;
  logic         call_pulse;
  logic [31:0]  call_ret_addr;
  logic         exc_entry;
  logic [8:0]   exc_num;
  logic         exc_return;
  cpr_int_req_t int_req;
  logic         int_accept;
  logic         fault;
  cpr_mode_t    mode;
  logic         proc_stack_sel;
  logic         privileged;
  logic         irq;
  int           miscompares;
  int           comparisons;

  cpr_core_state i_cpr_core_state (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpr_req(gpr_req), .gpr_rdata(gpr_rdata), .call_pulse(call_pulse),
    .call_ret_addr(call_ret_addr), .exc_entry(exc_entry), .exc_num(exc_num),
    .exc_return(exc_return), .int_req(int_req), .int_accept(int_accept), .fault(fault),
    .mode(mode), .proc_stack_sel(proc_stack_sel), .privileged(privileged), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Each access ends one settle step after the sampling edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic gp(input logic w, input logic s, input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    gpr_req <= '{valid: 1'b1, wr: w, is16: s, idx: i, wdata: d};
    @(posedge clk);
    gpr_req.valid <= 1'b0;
    #1;
  endtask

  task automatic ev(input logic c, input logic e, input logic r);
    @(posedge clk);
    call_pulse <= c;
    exc_entry  <= e;
    exc_return <= r;
    @(posedge clk);
    {call_pulse, exc_entry, exc_return} <= 3'h0;
    #1;
  endtask

  task automatic q(input logic n, input logic h, input logic [8:0] p, input logic exp);
    @(posedge clk);
    int_req <= '{valid: 1'b1, nmi: n, hardfault: h, prio: p};
    @(posedge clk);
    int_req.valid <= 1'b0;
    #1;
    chk({31'h0, int_accept}, {31'h0, exp});
  endtask

  task automatic st(input logic [1:0] m, input logic p, input logic s);
    chk({28'h0, mode, privileged, proc_stack_sel}, {28'h0, m, p, s});
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    #200us;
    miscompares++;
    finish_test();
  end

  initial
  begin
    miscompares = 0;
    comparisons = 0;
    reset_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd, call_pulse, call_ret_addr} = '0;
    {exc_entry, exc_num, exc_return} = '0;
    gpr_req = '0;
    int_req = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    st(2'b00, 1'b1, 1'b0);
    rd(CPR_OFF_PSR, 32'h0100_0000);
    wr(CPR_OFF_PSR, 32'hFFFF_FFFF);
    chk({31'h0, fault}, 32'h0);
    rd(CPR_OFF_PSR, 32'hFF00_FC00);
    wr(CPR_OFF_PSR, 32'h0000_0000);
    chk({31'h0, fault}, 32'h1);
    rd(CPR_OFF_PSR, 32'h0100_0000);
    gp(1'b1, 1'b0, 4'hD, 32'h0000_1237);
    rd(8'h34, 32'h0000_1234);
    rd(CPR_OFF_MAIN_STACK, 32'h0000_1234);
    gp(1'b1, 1'b0, 4'hF, 32'h0000_2001);
    rd(8'h3C, 32'h0000_2000);
    gp(1'b1, 1'b0, 4'h3, 32'hA5A5_5A5A);
    gp(1'b0, 1'b0, 4'h3, 32'h0);
    chk(gpr_rdata, 32'hA5A5_5A5A);
    gp(1'b1, 1'b1, 4'h9, 32'h11);
    chk({31'h0, fault}, 32'h1);
    rd(8'h24, 32'h0);
    gp(1'b1, 1'b0, 4'h9, 32'h22);
    chk({31'h0, fault}, 32'h0);
    rd(8'h24, 32'h22);
    gp(1'b1, 1'b1, 4'h7, 32'h77);
    chk({31'h0, fault}, 32'h0);
    call_ret_addr <= 32'h0800_0101;
    ev(1'b1, 1'b0, 1'b0);
    rd(8'h38, 32'h0800_0101);
    q(1'b0, 1'b0, 9'd5, 1'b1);
    wr(CPR_OFF_PRIO_MASK, 32'h1);
    q(1'b0, 1'b0, 9'd5, 1'b0);
    q(1'b0, 1'b1, 9'd5, 1'b1);
    wr(CPR_OFF_FAULT_MASK, 32'h1);
    q(1'b0, 1'b1, 9'd5, 1'b0);
    q(1'b1, 1'b0, 9'd5, 1'b1);
    wr(CPR_OFF_PRIO_MASK, 32'h0);
    wr(CPR_OFF_FAULT_MASK, 32'h0);
    wr(CPR_OFF_BASE_PRIO, 32'h4);
    q(1'b0, 1'b0, 9'd4, 1'b0);
    q(1'b0, 1'b0, 9'd3, 1'b1);
    wr(CPR_OFF_BASE_PRIO, 32'h0);
    // Sticky status, mask and level interrupt.
    wr(CPR_OFF_IRQ_STAT, 32'hF);
    wr(CPR_OFF_IRQ_MASK, 32'h0);
    gp(1'b1, 1'b1, 4'hA, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    wr(CPR_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1);
    rd(CPR_OFF_IRQ_STAT, 32'h1);
    rd(CPR_OFF_IRQ_MASK, 32'h1);
    wr(CPR_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    wr(CPR_OFF_PROC_STACK, 32'h2000_0010);
    wr(CPR_OFF_CONTROL, 32'h3);
    st(2'b01, 1'b0, 1'b1);
    wr(CPR_OFF_BASE_PRIO, 32'h7);
    chk({31'h0, fault}, 32'h1);
    exc_num <= 9'h10B;
    ev(1'b0, 1'b1, 1'b0);
    st(2'b11, 1'b1, 1'b0);
    rd(CPR_OFF_PSR, 32'h0100_010B);
    rd(CPR_OFF_BASE_PRIO, 32'h0);
    ev(1'b0, 1'b0, 1'b1);
    st(2'b01, 1'b0, 1'b1);
    rd(CPR_OFF_MODE, 32'h0000_0001);
    finish_test();
  end
endmodule

`default_nettype wire
